// file: rtl/dmove_consts.vh
// constants for the data-move instruction execution block
`ifndef DMOVE_CONSTS_VH
`define DMOVE_CONSTS_VH

// opcode fields
`define OPC_COPY 6'h14
`define OPC_MOVE1 4'hc
`define OPC_MOVE2 4'hf
`define OPC_BANK 8'h01

// instruction kinds
`define K_NOP 3'h0
`define K_COPY 3'h1
`define K_MOVE1 3'h2
`define K_MOVE2 3'h3
`define K_BANK 3'h4

// instruction phases
`define PH_DECODE 2'h0
`define PH_READ 2'h1
`define PH_PROCESS 2'h2
`define PH_WRITE 2'h3

// memory-mapped special locations
`define ADDR_ACC 12'hff0
`define ADDR_PC_LOW 12'hff1
`define ADDR_STK_UPPER 12'hff2
`define ADDR_STK_HIGH 12'hff3
`define ADDR_STK_LOW 12'hff4

// access bank split: low part below this, upper part at and above
`define ACCESS_SPLIT 8'h60
`define ACCESS_HI_BANK 4'hf

// register byte offsets
`define REG_CTRL 5'h00
`define REG_ACC 5'h04
`define REG_BANK 5'h08
`define REG_STATUS 5'h0c
`define REG_INDEX 5'h10

// field positions
`define CTRL_EXT_BIT 0
`define ST_ZERO_BIT 0
`define ST_NEG_BIT 1
`define ST_REFUSED_BIT 2
`define ST_BADWORD_BIT 3
`define ST_PENDING_BIT 4

// reset values
`define RST_ACC 8'h00
`define RST_BANK 8'h00
`define RST_INDEX 12'h000

`endif

// file: rtl/phase_seq.v
// four-phase instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module phase_seq (
   // clock and control
   input wire i_clk_sys,
   input wire i_rstn,
   input wire i_ce,
   // phase
   output reg [1:0] o_phase
);
   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_phase <= 2'h0;
      end else if (i_ce) begin
         o_phase <= o_phase + 2'h1;
      end
   end
endmodule // phase_seq
`default_nettype wire

// file: rtl/data_move_exec.v
// execution of register copy, two-word move and bank load instructions
`timescale 1ns/1ps
`default_nettype none
`include "dmove_consts.vh"
module data_move_exec (
   // clock, reset, enable
   input wire i_clk_sys,
   input wire i_rstn,
   input wire i_ce,
   // instruction words from fetch
   input wire [15:0] i_instr,
   input wire i_instr_valid,
   output reg o_instr_ack,
   // data memory, one-cycle synchronous read
   output reg [11:0] o_mem_addr,
   output reg o_mem_re,
   output reg o_mem_we,
   output reg [7:0] o_mem_wdata,
   input wire [7:0] i_mem_rdata,
   // avalon-mm register slave
   input wire [4:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   // core state
   output reg [7:0] o_acc,
   output reg [7:0] o_bank_select,
   output reg o_flag_neg,
   output reg o_flag_zero
);
   localparam ST_RUN = 1'b0;
   localparam ST_MOVE2 = 1'b1;

   wire [1:0] phase;
   reg state_r;
   reg [2:0] kind_r;
   reg [11:0] addr_r;
   reg [11:0] dst_r;
   reg dest_file_r;
   reg [7:0] data_r;
   reg [7:0] lit_r;
   reg ext_en_r;
   reg [11:0] index_base_r;
   reg refused_r;
   reg badword_r;

   // decode of the word on the fetch port
   reg [2:0] dec_kind;
   reg [11:0] dec_addr;
   wire [7:0] fld_f = i_instr[7:0];
   wire fld_a = i_instr[8];
   wire [11:0] dst_word = i_instr[11:0];
   wire dst_prot = (dst_r == `ADDR_PC_LOW) || (dst_r == `ADDR_STK_UPPER) ||
      (dst_r == `ADDR_STK_HIGH) || (dst_r == `ADDR_STK_LOW);
   wire [7:0] src_val = (addr_r == `ADDR_ACC) ? o_acc : i_mem_rdata;

   always @* begin
      dec_kind = `K_NOP;
      dec_addr = 12'h000;
      if (i_instr[15:10] == `OPC_COPY) begin
         dec_kind = `K_COPY;
         if (fld_a) begin
            dec_addr = {o_bank_select[3:0], fld_f};
         end else if (ext_en_r && fld_f < `ACCESS_SPLIT) begin
            dec_addr = index_base_r + {4'h0, fld_f};
         end else if (fld_f < `ACCESS_SPLIT) begin
            dec_addr = {4'h0, fld_f};
         end else begin
            dec_addr = {`ACCESS_HI_BANK, fld_f};
         end
      end else if (i_instr[15:12] == `OPC_MOVE1) begin
         dec_kind = `K_MOVE1;
         dec_addr = i_instr[11:0];
      end else if (i_instr[15:8] == `OPC_BANK) begin
         dec_kind = `K_BANK;
      end
   end

   // avalon read mux
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      if (i_avs_address == `REG_CTRL) begin
         rd_mux[`CTRL_EXT_BIT] = ext_en_r;
      end else if (i_avs_address == `REG_ACC) begin
         rd_mux[7:0] = o_acc;
      end else if (i_avs_address == `REG_BANK) begin
         rd_mux[7:0] = o_bank_select;
      end else if (i_avs_address == `REG_STATUS) begin
         rd_mux[`ST_ZERO_BIT] = o_flag_zero;
         rd_mux[`ST_NEG_BIT] = o_flag_neg;
         rd_mux[`ST_REFUSED_BIT] = refused_r;
         rd_mux[`ST_BADWORD_BIT] = badword_r;
         rd_mux[`ST_PENDING_BIT] = state_r;
      end else if (i_avs_address == `REG_INDEX) begin
         rd_mux[11:0] = index_base_r;
      end
   end

   wire bus_wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   wire [7:0] wd = i_avs_writedata[7:0];
   reg refused_set;
   reg badword_set;

   phase_seq u_phase (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_ce(i_ce),
      .o_phase(phase)
   );

   always @* begin
      refused_set = 1'b0;
      badword_set = 1'b0;
      if (phase == `PH_PROCESS && kind_r == `K_MOVE2 && dst_prot) begin
         refused_set = 1'b1;
      end
      if (phase == `PH_DECODE && state_r == ST_MOVE2 && i_instr_valid &&
         i_instr[15:12] != `OPC_MOVE2) begin
         badword_set = 1'b1;
      end
   end

   always @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         state_r <= ST_RUN;
         kind_r <= `K_NOP;
         addr_r <= 12'h000;
         dst_r <= 12'h000;
         dest_file_r <= 1'b0;
         data_r <= 8'h00;
         lit_r <= 8'h00;
         ext_en_r <= 1'b0;
         index_base_r <= `RST_INDEX;
         refused_r <= 1'b0;
         badword_r <= 1'b0;
         o_instr_ack <= 1'b0;
         o_mem_addr <= 12'h000;
         o_mem_re <= 1'b0;
         o_mem_we <= 1'b0;
         o_mem_wdata <= 8'h00;
         o_avs_readdata <= 32'h0000_0000;
         o_avs_waitrequest <= 1'b1;
         o_acc <= `RST_ACC;
         o_bank_select <= `RST_BANK;
         o_flag_neg <= 1'b0;
         o_flag_zero <= 1'b0;
      end else if (i_ce) begin
         // bus slave: answer one cycle after the request shows
         if (!o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b1;
         end else if (i_avs_read || i_avs_write) begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata <= rd_mux;
         end
         if (bus_wr) begin
            if (i_avs_address == `REG_CTRL) begin
               ext_en_r <= wd[`CTRL_EXT_BIT];
            end else if (i_avs_address == `REG_ACC) begin
               o_acc <= wd;
            end else if (i_avs_address == `REG_BANK) begin
               o_bank_select <= {4'h0, wd[3:0]};
            end else if (i_avs_address == `REG_INDEX) begin
               index_base_r <= i_avs_writedata[11:0];
            end
         end
         // sticky errors: a set in the clearing cycle wins
         if (refused_set) begin
            refused_r <= 1'b1;
         end else if (bus_wr && i_avs_address == `REG_STATUS &&
            wd[`ST_REFUSED_BIT]) begin
            refused_r <= 1'b0;
         end
         if (badword_set) begin
            badword_r <= 1'b1;
         end else if (bus_wr && i_avs_address == `REG_STATUS &&
            wd[`ST_BADWORD_BIT]) begin
            badword_r <= 1'b0;
         end

         o_instr_ack <= 1'b0;
         o_mem_re <= 1'b0;
         case (phase)
            `PH_DECODE: begin
               kind_r <= `K_NOP;
               if (i_instr_valid) begin
                  o_instr_ack <= 1'b1;
                  if (state_r == ST_MOVE2) begin
                     // second word is a plain operand, no dummy read
                     state_r <= ST_RUN;
                     if (i_instr[15:12] == `OPC_MOVE2) begin
                        kind_r <= `K_MOVE2;
                        dst_r <= dst_word;
                     end
                  end else begin
                     kind_r <= dec_kind;
                     addr_r <= dec_addr;
                     dest_file_r <= i_instr[9];
                     lit_r <= i_instr[7:0];
                     if (dec_kind == `K_COPY || dec_kind == `K_MOVE1) begin
                        // accumulator source is taken from inside
                        o_mem_re <= (dec_addr != `ADDR_ACC);
                        o_mem_addr <= dec_addr;
                     end
                     if (dec_kind == `K_MOVE1) begin
                        state_r <= ST_MOVE2;
                     end
                  end
               end
            end
            `PH_READ: begin
               // memory returns read data at the end of this phase
            end
            `PH_PROCESS: begin
               if (kind_r == `K_COPY || kind_r == `K_MOVE1) begin
                  data_r <= src_val;
               end
               if (kind_r == `K_COPY && dest_file_r &&
                  addr_r != `ADDR_ACC) begin
                  o_mem_we <= 1'b1;
                  o_mem_addr <= addr_r;
                  o_mem_wdata <= src_val;
               end
               if (kind_r == `K_MOVE2 && !dst_prot &&
                  dst_r != `ADDR_ACC) begin
                  o_mem_we <= 1'b1;
                  o_mem_addr <= dst_r;
                  o_mem_wdata <= data_r;
               end
            end
            default: begin
               o_mem_we <= 1'b0;
               if (kind_r == `K_COPY) begin
                  o_flag_zero <= (data_r == 8'h00);
                  o_flag_neg <= data_r[7];
                  if (!dest_file_r || addr_r == `ADDR_ACC) begin
                     o_acc <= data_r;
                  end
               end
               if (kind_r == `K_MOVE2 && !dst_prot &&
                  dst_r == `ADDR_ACC) begin
                  o_acc <= data_r;
               end
               if (kind_r == `K_BANK) begin
                  // flags untouched; upper nibble forced to zero
                  o_bank_select <= {4'h0, lit_r[3:0]};
               end
            end
         endcase
      end
   end
endmodule // data_move_exec
`default_nettype wire

// file: test/data_move_exec_props.sv
// assertion checker for the data-move execution block
`timescale 1ns/1ps
`default_nettype none
`include "dmove_consts.vh"
module data_move_exec_props (
   // clock, reset, enable
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_ce,
   // instruction and data memory
   input wire logic o_instr_ack,
   input wire logic [11:0] o_mem_addr,
   input wire logic o_mem_re,
   input wire logic o_mem_we,
   input wire logic [7:0] o_mem_wdata,
   input wire logic [7:0] i_mem_rdata,
   // register bus and core state
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic [7:0] o_bank_select,
   input wire logic o_flag_neg,
   input wire logic o_flag_zero
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   chk_ack_once_per: assert property (
      o_instr_ack |=> !o_instr_ack [*3]) else $error("ack repeated");
   chk_read_in_q2: assert property (
      o_mem_re |-> o_instr_ack) else $error("read off phase");
   chk_write_in_q4: assert property (
      o_mem_we |-> $past(o_instr_ack, 2)) else $error("write off phase");
   chk_no_stack_dest: assert property (
      o_mem_we |-> !(o_mem_addr >= `ADDR_PC_LOW &&
      o_mem_addr <= `ADDR_STK_LOW)) else $error("protected write");
   chk_copy_writeback: assert property (
      o_mem_we && $past(o_mem_re, 2) |-> o_mem_addr == $past(o_mem_addr, 2)
      && o_mem_wdata == $past(i_mem_rdata)) else $error("bad writeback");
   chk_bank_upper_zero: assert property (
      o_bank_select[7:4] == 4'h0) else $error("bank upper set");
   chk_bank_cause: assert property (
      $changed(o_bank_select) |-> $past(o_instr_ack, 3) ||
      $past(i_avs_write && !o_avs_waitrequest)) else $error("bank moved");
   chk_flags_cause: assert property (
      $changed({o_flag_neg, o_flag_zero}) |-> $past(o_instr_ack, 3))
      else $error("flags moved");
   chk_bus_answer: assert property (
      (i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce
      |=> !o_avs_waitrequest) else $error("late bus answer");
   cover property (o_mem_re ##2 o_mem_we);
   cover property ($changed(o_bank_select));
   cover property (o_mem_we && !$past(o_mem_re, 2));
endmodule // data_move_exec_props
bind data_move_exec data_move_exec_props u_props (.i_clk_sys, .i_rstn,
   .i_ce, .o_instr_ack, .o_mem_addr, .o_mem_re, .o_mem_we, .o_mem_wdata,
   .i_mem_rdata, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
   .o_bank_select, .o_flag_neg, .o_flag_zero);
`default_nettype wire

// file: test/test_data_move_instruction_exec.sv
// self-checking bench for the data-move execution block
`timescale 1ns/1ps
`default_nettype none
module test_data_move_instruction_exec;
   logic i_clk_sys = 0;
   logic i_rstn = 0;
   logic [15:0] i_instr = '0;
   logic i_instr_valid = 0;
   logic [7:0] i_mem_rdata = '0;
   logic [4:0] i_avs_address = '0;
   logic i_avs_read = 0;
   logic i_avs_write = 0;
   logic [31:0] i_avs_writedata = '0;
   wire o_instr_ack, o_mem_re, o_mem_we, o_avs_waitrequest;
   wire o_flag_neg, o_flag_zero;
   wire [11:0] o_mem_addr;
   wire [7:0] o_mem_wdata, o_acc, o_bank_select;
   wire [31:0] o_avs_readdata;
   logic [1:0] ph = '0;
   logic [11:0] re_addr = '0;
   logic [11:0] we_addr = '0;
   logic [7:0] we_data = '0;
   logic [31:0] rd;
   int we_cnt = 0;
   int re_cnt = 0;
   int errors = 0;
   int n_compared = 0;
   data_move_exec u_dut (.i_clk_sys, .i_rstn, .i_ce(1'b1), .i_instr,
      .i_instr_valid, .o_instr_ack, .o_mem_addr, .o_mem_re, .o_mem_we,
      .o_mem_wdata, .i_mem_rdata, .i_avs_address, .i_avs_read,
      .i_avs_write, .i_avs_writedata, .i_avs_byteenable(4'hf),
      .o_avs_readdata, .o_avs_waitrequest, .o_acc, .o_bank_select,
      .o_flag_neg, .o_flag_zero);
   always #4 i_clk_sys = ~i_clk_sys;
   // mirror of the phase counter plus a memory that answers addr ^ a5
   always @(posedge i_clk_sys) begin
      ph <= i_rstn ? ph + 2'h1 : 2'h0;
      i_mem_rdata <= o_mem_addr[7:0] ^ 8'ha5;
      if (o_mem_re) begin
         re_addr <= o_mem_addr;
         re_cnt <= re_cnt + 1;
      end
      if (o_mem_we) begin
         we_addr <= o_mem_addr;
         we_data <= o_mem_wdata;
         we_cnt <= we_cnt + 1;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      if (errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [4:0] a,
         input logic [31:0] d);
      @(posedge i_clk_sys);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      @(posedge i_clk_sys);
      while (o_avs_waitrequest !== 1'b0) @(posedge i_clk_sys);
      rd = o_avs_readdata;
      i_avs_write <= 0;
      i_avs_read <= 0;
   endtask
   // hold keeps valid up so a second word follows without a gap
   task automatic word(input logic [15:0] w, input logic hold);
      while (ph != 2'h3) @(posedge i_clk_sys);
      i_instr <= w;
      i_instr_valid <= 1;
      repeat (4) @(posedge i_clk_sys);
      if (!hold) i_instr_valid <= 0;
   endtask
   task automatic copy(input logic d, a, input logic [7:0] f,
         input logic [11:0] ea);
      int n;
      logic [7:0] x;
      logic [7:0] acc0;
      n = we_cnt;
      acc0 = o_acc;
      x = ea[7:0] ^ 8'ha5;
      word({6'h14, d, a, f}, 0);
      #1;
      chk(re_addr, ea);
      chk(we_cnt - n, d);
      chk({o_flag_neg, o_flag_zero}, {x[7], x == 8'h00});
      if (d) chk({we_addr, we_data}, {ea, x});
      else chk(o_acc, x);
      if (d) chk(o_acc, acc0);
   endtask
   // kind: 0 refused destination, 1 memory write, 2 accumulator
   task automatic move(input logic [11:0] s, dd, input logic [7:0] x,
         input int kind);
      int n;
      logic [1:0] fl;
      int r;
      n = we_cnt;
      r = re_cnt;
      fl = {o_flag_neg, o_flag_zero};
      word({4'hc, s}, 1);
      word({4'hf, dd}, 0);
      #1;
      chk({o_flag_neg, o_flag_zero}, fl);
      if (s != 12'hff0) chk(re_cnt - r, 1);
      if (kind == 2) chk(o_acc, x);
      else chk(we_cnt - n, kind);
      if (kind == 1) chk({we_addr, we_data}, {dd, x});
   endtask
   // bus view of the bank select register and of an unmapped offset
   task automatic bank_regs;
      bus(1, 5'h08, 32'h0000_00ff);
      bus(0, 5'h08, 0);
      chk(rd, 32'h0000_000f);
      bus(0, 5'h14, 0);
      chk(rd, 32'h0000_0000);
   endtask
   task automatic bank_load(input logic [7:0] k);
      logic [1:0] fl;
      fl = {o_flag_neg, o_flag_zero};
      word({8'h01, k}, 0);
      #1;
      chk(o_bank_select, {4'h0, k[3:0]});
      chk({o_flag_neg, o_flag_zero}, fl);
   endtask
   // a non-move second word drops the pair; sticky bits clear on a 1
   task automatic status_w1c;
      int n;
      n = we_cnt;
      word({4'hc, 12'h010}, 1);
      word(16'h0000, 0);
      #1;
      chk(we_cnt - n, 0);
      bus(0, 5'h0c, 0);
      chk(rd, 32'h0000_000e);
      bus(1, 5'h0c, 32'h0000_000c);
      bus(0, 5'h0c, 0);
      chk(rd, 32'h0000_0002);
   endtask
   initial begin
      #20000;
      errors++;
      stop_test;
   end
   initial begin
      repeat (5) @(posedge i_clk_sys);
      i_rstn <= 1;
      chk({o_acc, o_bank_select, o_avs_waitrequest}, 17'h0_0001);
      bank_regs;
      bank_load(8'hc5);
      copy(0, 1, 8'h34, 12'h534);
      copy(1, 1, 8'h07, 12'h507);
      copy(0, 0, 8'h20, 12'h020);
      copy(0, 0, 8'ha5, 12'hfa5);
      bus(1, 5'h00, 32'h0000_0001);
      bus(1, 5'h10, 32'h0000_0200);
      copy(0, 0, 8'h5f, 12'h25f);
      copy(0, 0, 8'h60, 12'hf60);
      move(12'h123, 12'habc, 8'h86, 1);
      move(12'h1a5, 12'h3c0, 8'h00, 1);
      move(12'h03c, 12'hff0, 8'h99, 2);
      move(12'hff0, 12'h100, 8'h99, 1);
      for (int i = 1; i < 5; i++) move(12'h050, 12'hff0 + i, 8'h00, 0);
      status_w1c;
      bank_load(8'h3a);
      stop_test;
   end
endmodule // test_data_move_instruction_exec
`default_nettype wire
